// File: common/bdu_pkg.sv
`default_nettype none
package bdu_pkg;

  // ----------------------------------------------------------------
  // opcodes
  // ----------------------------------------------------------------
  localparam logic [3:0] ADJ_OP_HI = 4'hD;
  localparam logic [7:0] DECR_ACC_OP = 8'h14;
  localparam logic [7:0] DECR_DIR_OP = 8'h15;

  // ----------------------------------------------------------------
  // arithmetic constants
  // ----------------------------------------------------------------
  localparam logic [3:0] BCD_MAX = 4'h9;
  localparam logic [3:0] BCD_FIX = 4'h6;
  localparam logic [7:0] DECR_STEP = 8'h01;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [7:0] BYTE_FULL = 8'hFF;

  // ----------------------------------------------------------------
  // state counts and port addresses
  // ----------------------------------------------------------------
  localparam logic [2:0] STATES_DIR = 3'h2;
  localparam logic [2:0] STATES_PORT_EXTRA = 3'h2;
  localparam logic [2:0] CNT_LAST = 3'h1;
  localparam logic [7:0] PORT0_ADDR = 8'h80;
  localparam logic [7:0] PORT1_ADDR = 8'h90;
  localparam logic [7:0] PORT2_ADDR = 8'hA0;
  localparam logic [7:0] PORT3_ADDR = 8'hB0;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic carry_flag;
    logic aux_carry_flag;
    logic overflow_flag;
    logic neg;
    logic zero;
  } bdu_flags_s;

  typedef struct packed {
    logic valid;
    logic [7:0] opcode;
    logic [7:0] dir_addr;
    logic [7:0] acc;
    bdu_flags_s flags;
  } bdu_req_s;

  typedef enum logic [1:0] {
    BDU_IDLE = 2'b00,
    BDU_READ = 2'b01,
    BDU_WAIT = 2'b10
  } bdu_state_e;

endpackage
`default_nettype wire

// File: src/bdu_core.sv
// Contract
// - adjust adds six to a nibble above nine or with its carry flag set
// - adjust sets carry when the result overflows two decimal digits
// - a nibble fix without carry out leaves carry as it was
// - adjust leaves the overflow flag unchanged
// - adjust opcode has upper nibble 1101, one byte, one state
// - decrement subtracts one and writes back to the same place
// - port decrement reads the output latch, not the pins
// - accumulator decrement is opcode 0001 0100, one state
`timescale 1ns/100ps
`default_nettype none
module bdu_core #(
  parameter int DATA_W = 8
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic en_i,
  input wire bdu_pkg::bdu_req_s req_i,
  input wire logic [7:0] rd_data_i,
  output logic busy_o,
  output logic done_o,
  output logic illegal_o,
  output logic [7:0] acc_o,
  output bdu_pkg::bdu_flags_s flags_o,
  output logic rd_o,
  output logic rd_latch_o,
  output logic [7:0] rd_addr_o,
  output logic wr_o,
  output logic [7:0] wr_addr_o,
  output logic [7:0] wr_data_o
);

  // ----------------------------------------------------------------
  // elaboration check
  // ----------------------------------------------------------------
  if (DATA_W != 8) begin : g_bad_width
    $error("bdu_core serves byte operands only");
  end

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  function automatic logic is_port(input logic [7:0] a);
    is_port = (a == bdu_pkg::PORT0_ADDR) || (a == bdu_pkg::PORT1_ADDR) ||
              (a == bdu_pkg::PORT2_ADDR) || (a == bdu_pkg::PORT3_ADDR);
  endfunction

  // two-step adjust; carry only ever set, never cleared here
  function automatic logic [8:0] adj_calc(input logic [7:0] a, input logic cin,
                                          input logic aux);
    logic [8:0] t;
    logic c;
    t = {1'b0, a};
    c = cin;
    if (a[3:0] > bdu_pkg::BCD_MAX || aux) begin
      t = t + {5'h00, bdu_pkg::BCD_FIX};
      c = c | t[8];
    end
    if (t[7:4] > bdu_pkg::BCD_MAX || c) begin
      t = {1'b0, t[7:0]} + {1'b0, bdu_pkg::BCD_FIX, 4'h0};
      c = c | t[8];
    end
    adj_calc = {c, t[7:0]};
  endfunction

  bdu_pkg::bdu_state_e state_r;
  logic [2:0] cnt_r;
  logic [8:0] adj_res;
  logic [7:0] decr_acc;
  logic [7:0] decr_mem;
  logic [7:0] wb_val;
  logic idle;
  logic take_adj;
  logic take_deca;
  logic take_dir;

  assign idle = (state_r == bdu_pkg::BDU_IDLE);
  assign take_adj = idle && req_i.valid && (req_i.opcode[7:4] == bdu_pkg::ADJ_OP_HI);
  assign take_deca = idle && req_i.valid && (req_i.opcode == bdu_pkg::DECR_ACC_OP);
  assign take_dir = idle && req_i.valid && (req_i.opcode == bdu_pkg::DECR_DIR_OP);
  assign adj_res = adj_calc(req_i.acc, req_i.flags.carry_flag, req_i.flags.aux_carry_flag);
  // plain modulo subtract: 00H wraps, no error path exists
  assign decr_acc = req_i.acc - bdu_pkg::DECR_STEP;
  assign decr_mem = rd_data_i - bdu_pkg::DECR_STEP;
  // a plain direct decrement ends in its read state, before wr_data_o is loaded
  assign wb_val = (state_r == bdu_pkg::BDU_READ) ? decr_mem : wr_data_o;

  // ----------------------------------------------------------------
  // sequencing and memory side
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_r <= bdu_pkg::BDU_IDLE;
      cnt_r <= 3'h0;
      busy_o <= 1'b0;
      rd_o <= 1'b0;
      rd_latch_o <= 1'b0;
      rd_addr_o <= 8'h00;
      wr_o <= 1'b0;
      wr_addr_o <= 8'h00;
      wr_data_o <= 8'h00;
    end else if (en_i) begin
      rd_o <= 1'b0;
      wr_o <= 1'b0;
      unique case (state_r)
        bdu_pkg::BDU_IDLE: begin
          if (take_dir) begin
            state_r <= bdu_pkg::BDU_READ;
            busy_o <= 1'b1;
            rd_o <= 1'b1;
            rd_addr_o <= req_i.dir_addr;
            rd_latch_o <= is_port(req_i.dir_addr);
            cnt_r <= is_port(req_i.dir_addr) ? bdu_pkg::STATES_PORT_EXTRA : 3'h0;
          end
        end
        bdu_pkg::BDU_READ: begin
          // data is captured now; port accesses then idle for the extra states
          wr_addr_o <= rd_addr_o;
          wr_data_o <= decr_mem;
          if (cnt_r == 3'h0) begin
            state_r <= bdu_pkg::BDU_IDLE;
            busy_o <= 1'b0;
            wr_o <= 1'b1;
          end else begin
            state_r <= bdu_pkg::BDU_WAIT;
          end
        end
        bdu_pkg::BDU_WAIT: begin
          if (cnt_r == bdu_pkg::CNT_LAST) begin
            state_r <= bdu_pkg::BDU_IDLE;
            busy_o <= 1'b0;
            wr_o <= 1'b1;
          end
          cnt_r <= cnt_r - 3'h1;
        end
        default: begin
          state_r <= bdu_pkg::BDU_IDLE;
          busy_o <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // completion and result
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      done_o <= 1'b0;
      illegal_o <= 1'b0;
      acc_o <= 8'h00;
      flags_o <= '0;
    end else if (en_i) begin
      done_o <= 1'b0;
      illegal_o <= 1'b0;
      if (take_adj) begin
        done_o <= 1'b1;
        acc_o <= adj_res[7:0];
        flags_o <= req_i.flags;
        flags_o.carry_flag <= adj_res[8];
        flags_o.neg <= adj_res[7];
        flags_o.zero <= (adj_res[7:0] == bdu_pkg::BYTE_ZERO);
      end else if (take_deca) begin
        done_o <= 1'b1;
        acc_o <= decr_acc;
        flags_o <= req_i.flags;
        flags_o.neg <= decr_acc[7];
        flags_o.zero <= (decr_acc == bdu_pkg::BYTE_ZERO);
      end else if (idle && req_i.valid && !take_dir) begin
        done_o <= 1'b1;
        illegal_o <= 1'b1;
      end else if ((state_r == bdu_pkg::BDU_READ && cnt_r == 3'h0) ||
                   (state_r == bdu_pkg::BDU_WAIT && cnt_r == bdu_pkg::CNT_LAST)) begin
        done_o <= 1'b1;
        flags_o.neg <= wb_val[7];
        flags_o.zero <= (wb_val == bdu_pkg::BYTE_ZERO);
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i || !en_i);

  logic [7:0] acc_in;
  assign acc_in = req_i.acc;

  sequence s_mem_read;
    rd_o && !rd_latch_o;
  endsequence
  sequence s_port_read;
    rd_o && rd_latch_o;
  endsequence
  sequence s_write_done;
    wr_o && done_o && !busy_o;
  endsequence

  AST_ADJ_LOW_FIX: assert property (take_adj && acc_in[3:0] > bdu_pkg::BCD_MAX |=>
    acc_o[3:0] == 4'($past(acc_in[3:0]) + bdu_pkg::BCD_FIX))
    else $error("low nibble not corrected");
  AST_ADJ_NO_FIX: assert property (take_adj && acc_in[3:0] <= bdu_pkg::BCD_MAX &&
    acc_in[7:4] <= bdu_pkg::BCD_MAX && !req_i.flags.aux_carry_flag &&
    !req_i.flags.carry_flag |=> acc_o == $past(acc_in) && !flags_o.carry_flag)
    else $error("valid bcd changed");
  AST_ADJ_CARRY: assert property (take_adj && acc_in[7:4] > bdu_pkg::BCD_MAX |=>
    flags_o.carry_flag)
    else $error("decimal overflow without carry");
  AST_ADJ_CARRY_KEEP: assert property (take_adj && req_i.flags.carry_flag |=>
    flags_o.carry_flag)
    else $error("adjust cleared carry");
  AST_ADJ_OVF: assert property (take_adj |=>
    flags_o.overflow_flag == $past(req_i.flags.overflow_flag))
    else $error("adjust touched overflow");
  AST_ONE_STATE: assert property ((take_adj || take_deca) |=>
    done_o && !busy_o && !rd_o)
    else $error("one-state op not done in one state");
  AST_DECR_ACC: assert property (take_deca |=>
    acc_o == 8'($past(acc_in) - bdu_pkg::DECR_STEP))
    else $error("accumulator decrement wrong");
  AST_DECR_WRAP: assert property (take_deca && acc_in == bdu_pkg::BYTE_ZERO |=>
    acc_o == bdu_pkg::BYTE_FULL && !illegal_o)
    else $error("decrement did not wrap");
  AST_DIR_MEM: assert property (take_dir && !is_port(req_i.dir_addr) |=>
    s_mem_read ##1 s_write_done)
    else $error("direct decrement not two states");
  AST_DIR_PORT: assert property (take_dir && is_port(req_i.dir_addr) |=>
    s_port_read ##1 (!wr_o && !done_o) [*2] ##1 s_write_done)
    else $error("port decrement sequence wrong");
  AST_WRITE_BACK: assert property (rd_o ##1 1'b1 |->
    wr_addr_o == $past(rd_addr_o) && wr_data_o == 8'($past(rd_data_i) - bdu_pkg::DECR_STEP))
    else $error("write back mismatch");

endmodule
`default_nettype wire

// File: verification/bdu_mem_model.sv
`timescale 1ns/100ps
`default_nettype none
module bdu_mem_model (
  input wire logic clk_i,
  input wire logic rd_i,
  input wire logic rd_latch_i,
  input wire logic [7:0] rd_addr_i,
  input wire logic wr_i,
  input wire logic [7:0] wr_addr_i,
  input wire logic [7:0] wr_data_i,
  output logic [7:0] rd_data_o
);
  logic [7:0] mem [256];
  logic [7:0] last_r;

  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = i[7:0];
    end
    last_r = 8'h00;
  end

  // port pins show the inverse of the latch, so a pin read is caught
  always_comb begin
    if (!rd_i) begin
      rd_data_o = ~last_r;
    end else if (rd_addr_i[7:6] == 2'b10 && rd_addr_i[3:0] == 4'h0 && !rd_latch_i) begin
      rd_data_o = ~mem[rd_addr_i];
    end else begin
      rd_data_o = mem[rd_addr_i];
    end
  end

  always @(posedge clk_i) begin
    if (rd_i) begin
      last_r <= rd_data_o;
    end
    if (wr_i) begin
      mem[wr_addr_i] <= wr_data_i;
    end
  end
endmodule
`default_nettype wire

// File: verification/tb_bcd_adjust_and_decrement_unit.sv
`timescale 1ns/100ps
`default_nettype none
module tb_bcd_adjust_and_decrement_unit;
  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic en_i = 1'b1;
  bdu_pkg::bdu_req_s req_i = '0;
  logic [7:0] rd_data_i;
  logic busy_o, done_o, illegal_o, rd_o, rd_latch_o, wr_o;
  logic [7:0] acc_o, rd_addr_o, wr_addr_o, wr_data_o;
  bdu_pkg::bdu_flags_s flags_o;
  int fail_count = 0;
  int total_checks = 0;

  always #20 clk_i = ~clk_i;

  bdu_core i_dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .en_i(en_i), .req_i(req_i),
    .rd_data_i(rd_data_i), .busy_o(busy_o), .done_o(done_o), .illegal_o(illegal_o),
    .acc_o(acc_o), .flags_o(flags_o), .rd_o(rd_o), .rd_latch_o(rd_latch_o),
    .rd_addr_o(rd_addr_o), .wr_o(wr_o), .wr_addr_o(wr_addr_o), .wr_data_o(wr_data_o));

  bdu_mem_model i_mem (.clk_i(clk_i), .rd_i(rd_o), .rd_latch_i(rd_latch_o),
    .rd_addr_i(rd_addr_o), .wr_i(wr_o), .wr_addr_i(wr_addr_o), .wr_data_i(wr_data_o),
    .rd_data_o(rd_data_i));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic give_verdict();
    if (fail_count == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // carry is only ever set by a correction, never cleared
  function automatic logic [8:0] adj_ref(input logic [7:0] a, input logic cin, input logic aux);
    logic [8:0] s;
    s = {cin, a};
    if (s[3:0] > 4'h9 || aux) begin
      s = {s[8], 8'h00} | ({1'b0, s[7:0]} + 9'h006);
    end
    if (s[7:4] > 4'h9 || s[8]) begin
      s = {s[8], 8'h00} | ({1'b0, s[7:0]} + 9'h060);
    end
    return s;
  endfunction

  // one-state op; caller may chain these back to back
  task automatic one_op(input logic [7:0] op, input logic [7:0] a, input logic [2:0] cao,
      input logic [7:0] exp_acc, input logic exp_carry, input logic exp_ill);
    req_i = '{valid: 1'b1, opcode: op, dir_addr: 8'h00, acc: a, flags: {cao, 2'b00}};
    @(posedge clk_i);
    #1;
    check("done", 8'h01, {7'h0, done_o});
    check("illegal", {7'h0, exp_ill}, {7'h0, illegal_o});
    check("acc", exp_acc, acc_o);
    check("carry", {7'h0, exp_carry}, {7'h0, flags_o.carry_flag});
    check("ovf", {7'h0, cao[0]}, {7'h0, flags_o.overflow_flag});
    check("aux", {7'h0, cao[1]}, {7'h0, flags_o.aux_carry_flag});
    check("neg", {7'h0, exp_acc[7]}, {7'h0, flags_o.neg});
    check("zero", {7'h0, exp_acc == 8'h00}, {7'h0, flags_o.zero});
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic adj_cases();
    logic [7:0] av [6] = '{8'hBE, 8'hC9, 8'h9A, 8'h05, 8'h99, 8'h2F};
    logic [8:0] r;
    for (int i = 0; i < 6; i++) begin
      for (int f = 0; f < 8; f++) begin
        r = adj_ref(av[i], f[2], f[1]);
        one_op({bdu_pkg::ADJ_OP_HI, 4'(f + i)}, av[i], f[2:0],
          r[7:0], r[8], 1'b0);
      end
    end
  endtask

  task automatic decr_cases();
    logic [7:0] av [3] = '{8'h00, 8'h80, 8'h01};
    logic [2:0] c;
    for (int i = 0; i < 3; i++) begin
      c = 3'(i * 3);
      one_op(bdu_pkg::DECR_ACC_OP, av[i], c, av[i] - 8'h01, c[2], 1'b0);
    end
    one_op(8'h00, 8'h55, c, 8'h00, c[2], 1'b1);
  endtask

  task automatic dir_op(input logic [7:0] addr, input int n, input logic port);
    int k;
    logic latch;
    logic [7:0] raddr;
    logic [7:0] res;
    req_i = '{valid: 1'b1, opcode: bdu_pkg::DECR_DIR_OP, dir_addr: addr, acc: 8'h00, flags: '0};
    latch = 1'b0;
    raddr = ~addr;
    res = addr - 8'h01;
    @(posedge clk_i);
    #1;
    req_i.valid = 1'b0;
    k = 1;
    while (done_o !== 1'b1 && k < 8) begin
      if (rd_o === 1'b1) begin
        latch = rd_latch_o;
        raddr = rd_addr_o;
      end
      check("busy", 8'h01, {7'h0, busy_o});
      @(posedge clk_i);
      #1;
      k++;
    end
    check("states", 8'(n), 8'(k));
    check("latch", {7'h0, port}, {7'h0, latch});
    check("rd_addr", addr, raddr);
    check("wr", 8'h01, {7'h0, wr_o});
    check("wr_addr", addr, wr_addr_o);
    check("wr_data", res, wr_data_o);
    check("neg", {7'h0, res[7]}, {7'h0, flags_o.neg});
    check("zero", {7'h0, res == 8'h00}, {7'h0, flags_o.zero});
  endtask

  // clock enable low must hold every result until it returns
  task automatic freeze_case();
    req_i = '{valid: 1'b1, opcode: bdu_pkg::DECR_ACC_OP, dir_addr: 8'h00, acc: 8'h10, flags: '0};
    en_i = 1'b0;
    repeat (3) @(posedge clk_i);
    #1;
    check("frozen acc", 8'h00, acc_o);
    en_i = 1'b1;
    @(posedge clk_i);
    #1;
    check("thawed acc", 8'h0F, acc_o);
    check("thawed done", 8'h01, {7'h0, done_o});
    req_i.valid = 1'b0;
  endtask

  initial begin
    repeat (16) @(posedge clk_i);
    #1;
    check("rst acc", 8'h00, acc_o);
    check("rst done", 8'h00, {7'h0, done_o});
    rst_b_i = 1'b1;
    adj_cases();
    decr_cases();
    dir_op(8'h30, 2, 1'b0);
    dir_op(8'h00, 2, 1'b0);
    for (int i = 0; i < 4; i++) begin
      dir_op({2'b10, 2'(i), 4'h0}, 4, 1'b1);
    end
    freeze_case();
    give_verdict();
  end

  // whole run is well under a thousand cycles
  initial begin
    #(40 * 2000);
    fail_count++;
    give_verdict();
  end
endmodule
`default_nettype wire
